// ==== src/qudc_pkg.sv ====
/*
 * qudc_pkg: register map, field positions, reset values and mode codes
 * for the quadrature up/down position counter.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
package qudc_pkg;
    // register byte offsets
    localparam logic [4:0] QUDC_CTRL_OFS = 5'h00;
    localparam logic [4:0] QUDC_FILT_OFS = 5'h04;
    localparam logic [4:0] QUDC_CNT_OFS = 5'h08;
    localparam logic [4:0] QUDC_MAX_OFS = 5'h0c;
    localparam logic [4:0] QUDC_MIN_OFS = 5'h10;
    localparam logic [4:0] QUDC_STAT_OFS = 5'h14;
    localparam logic [4:0] QUDC_MISM_OFS = 5'h18;

    // control fields
    localparam int QUDC_CTRL_EN = 0;
    localparam int QUDC_CTRL_MODE_LO = 1; // 3-bit mode field [3:1]
    localparam int QUDC_CTRL_ZM_EN = 4; // zero marker clears count
    localparam int QUDC_CTRL_AZ = 5; // auto-zero on boundary
    localparam int QUDC_CTRL_FAULT = 6; // route mismatch to fault output

    // status fields (bits 0-3 write one to clear)
    localparam int QUDC_ST_MAX = 0;
    localparam int QUDC_ST_MIN = 1;
    localparam int QUDC_ST_MISM = 2;
    localparam int QUDC_ST_ZM = 3;
    localparam int QUDC_ST_BTN = 4; // live debounced third input

    localparam logic [31:0] QUDC_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] QUDC_FILT_RST = 16'h0004;
    localparam logic [31:0] QUDC_MAX_RST = 32'h7fff_ffff;
    localparam logic [31:0] QUDC_MIN_RST = 32'h8000_0000;
    localparam logic [15:0] QUDC_MISM_RST = 16'h0010;
    localparam logic [31:0] QUDC_UNMAPPED = 32'h0000_0000;

    typedef enum logic [2:0] {
        QUDC_M_QUAD, // quadrature decode
        QUDC_M_BIN, // binary code decode
        QUDC_M_DIRLVL, // pin b sets direction, pin a counts
        QUDC_M_DIREDGE, // pin a edges count up, pin b edges down
        QUDC_M_MISM // mismatch monitor on a/b edge pair
    } qudc_mode_t;
endpackage : qudc_pkg

// ==== src/qudc_debounce.sv ====
/*
 * qudc_debounce: one debounce filter for one counter input.
 * Assumes the input is already synchronous to clk_sys.
 */
`timescale 1ns/100ps
module qudc_debounce (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic raw_in,
    input wire logic [15:0] filt_cycles,
    output logic level_q
);
    logic [15:0] stable_q;
    logic [15:0] stable_d;
    logic differs;

    // a pending level must hold for filt_cycles clocks before it is taken
    assign differs = raw_in != level_q;
    assign stable_d = differs ? stable_q + 16'h0001 : 16'h0000;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stable_q <= 16'h0000;
            level_q <= 1'b0;
        end else if (differs && stable_d >= filt_cycles) begin
            stable_q <= 16'h0000;
            level_q <= raw_in; // see [RULE11]
        end else begin
            stable_q <= stable_d;
        end
    end
endmodule : qudc_debounce

// ==== src/qudc_counter.sv ====
/*
 * qudc_counter: 32-bit up/down position counter with quadrature, binary
 * and direction-controlled modes, zero marker, boundaries and an up/down
 * mismatch monitor, reached over Avalon-MM.
 * Assumes encoder pins already synchronous to clk_sys.
 */
// Summary of operation
// [RULE1] 32-bit count steps up or down
// [RULE2] decode two-bit quadrature or binary code
// [RULE3] direction from level pin or edges
// [RULE4] third input: zero marker or push button
// [RULE5] all three inputs debounced, programmable interval
// [RULE6] count events forwarded to timer
// [RULE7] boundary exceeded: auto-zero or warning interrupt
// [RULE8] monitor pair: one edge up, other down
// [RULE9] mismatch outside range flags processor or fault
// [RULE10] gray steps count, double jumps ignored
// [RULE11] level taken after programmed stable cycles
`timescale 1ns/100ps
module qudc_counter
    import qudc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    output logic count_up_evt,
    output logic count_dn_evt,
    output logic count_evt,
    output logic warn_irq,
    output logic mism_fault
);
    logic [31:0] ctrl_q;
    logic [15:0] filt_q;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] max_q;
    logic [31:0] min_q;
    logic [15:0] mism_q;
    logic [3:0] stat_q;
    logic [3:0] stat_d;
    logic [31:0] diff_q;
    logic [31:0] diff_d;
    logic [31:0] rdata_d;
    logic ack_q;
    logic a_f;
    logic b_f;
    logic z_f;
    logic [1:0] ab_q;
    logic z_q;

    // debounce all three pins with the same programmed interval
    qudc_debounce u_deb_a (.clk_sys(clk_sys), .reset_n(reset_n),
        .raw_in(enc_a), .filt_cycles(filt_q), .level_q(a_f)); // see [RULE5]
    qudc_debounce u_deb_b (.clk_sys(clk_sys), .reset_n(reset_n),
        .raw_in(enc_b), .filt_cycles(filt_q), .level_q(b_f)); // see [RULE5]
    qudc_debounce u_deb_z (.clk_sys(clk_sys), .reset_n(reset_n),
        .raw_in(enc_z), .filt_cycles(filt_q), .level_q(z_f)); // see [RULE5]

    // gray position index of a two-bit code
    function automatic logic [1:0] qudc_gray_pos(input logic [1:0] c);
        qudc_gray_pos = {c[1], c[1] ^ c[0]};
    endfunction : qudc_gray_pos

    // mode and edge decoding
    wire enabled = ctrl_q[QUDC_CTRL_EN];
    wire [2:0] mode_raw = ctrl_q[QUDC_CTRL_MODE_LO +: 3];
    wire [1:0] ab_now = {b_f, a_f};
    wire a_rise = a_f & ~ab_q[0];
    wire b_rise = b_f & ~ab_q[1];
    wire z_rise = z_f & ~z_q;
    wire [1:0] pos_new = qudc_gray_pos(ab_now);
    wire [1:0] pos_old = qudc_gray_pos(ab_q);
    wire [1:0] q_step = pos_new - pos_old;
    wire [1:0] b_step = ab_now - ab_q;

    // one step per gray move; a two-position jump is illegal
    wire quad_up = q_step == 2'h1; // see [RULE10]
    wire quad_dn = q_step == 2'h3; // see [RULE10]
    // binary code: wheel moves one code per detent, wraps at 3
    wire bin_up = b_step == 2'h1; // see [RULE2]
    wire bin_dn = b_step == 2'h3; // see [RULE2]

    logic step_up;
    logic step_dn;
    logic mism_mode;
    // pick step source by mode; illegal mode codes count nothing
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        mism_mode = 1'b0;
        case (mode_raw)
            QUDC_M_QUAD: begin
                step_up = quad_up; // see [RULE2]
                step_dn = quad_dn;
            end
            QUDC_M_BIN: begin
                step_up = bin_up;
                step_dn = bin_dn;
            end
            QUDC_M_DIRLVL: begin
                step_up = a_rise & ~b_f; // see [RULE3]
                step_dn = a_rise & b_f;
            end
            QUDC_M_DIREDGE: begin
                step_up = a_rise; // see [RULE3]
                step_dn = b_rise;
            end
            QUDC_M_MISM: begin
                mism_mode = 1'b1; // see [RULE8]
            end
            default: begin
                step_up = 1'b0;
            end
        endcase
    end

    wire go_up = enabled & step_up & ~step_dn;
    wire go_dn = enabled & step_dn & ~step_up;
    // zero marker only acts when selected; otherwise z is a push button
    wire zm_hit = enabled & ctrl_q[QUDC_CTRL_ZM_EN] & z_rise; // see [RULE4]
    wire [31:0] cnt_step = go_up ? cnt_q + 32'h1 :
                           go_dn ? cnt_q - 32'h1 : cnt_q; // see [RULE1]
    wire over_max = go_up && $signed(cnt_step) > $signed(max_q);
    wire under_min = go_dn && $signed(cnt_step) < $signed(min_q);
    wire auto_zero = ctrl_q[QUDC_CTRL_AZ] & (over_max | under_min);

    // mismatch monitor: a edges add, b edges subtract
    wire mon_up = enabled & mism_mode & a_rise & ~b_rise; // see [RULE8]
    wire mon_dn = enabled & mism_mode & b_rise & ~a_rise; // see [RULE8]
    assign diff_d = mon_up ? diff_q + 32'h1 :
                    mon_dn ? diff_q - 32'h1 : diff_q;
    wire [31:0] mism_lim = {16'h0000, mism_q};
    wire mism_hit = $signed(diff_d) > $signed(mism_lim) ||
                    $signed(diff_d) < -$signed(mism_lim); // see [RULE9]

    // register access decode
    wire wr_ack = avs_write & ~ack_q;
    wire wr_ctrl = wr_ack && avs_address == QUDC_CTRL_OFS;
    wire wr_filt = wr_ack && avs_address == QUDC_FILT_OFS;
    wire wr_cnt = wr_ack && avs_address == QUDC_CNT_OFS;
    wire wr_max = wr_ack && avs_address == QUDC_MAX_OFS;
    wire wr_min = wr_ack && avs_address == QUDC_MIN_OFS;
    wire wr_stat = wr_ack && avs_address == QUDC_STAT_OFS;
    wire wr_mism = wr_ack && avs_address == QUDC_MISM_OFS;

    // auto-zero and zero marker win over stepping; software write wins all
    assign cnt_d = wr_cnt ? avs_writedata :
                   (zm_hit | auto_zero) ? 32'h0 : cnt_step; // see [RULE7]

    // sticky flags: a new event beats a same-cycle clear
    assign stat_d = (stat_q & ~({4{wr_stat}} & avs_writedata[3:0]))
                  | {zm_hit, mism_hit & mism_mode & enabled,
                     under_min, over_max}; // see [RULE7]

    // read mux; unmapped words read zero
    always_comb begin
        case (avs_address)
            QUDC_CTRL_OFS: rdata_d = ctrl_q;
            QUDC_FILT_OFS: rdata_d = {16'h0000, filt_q};
            QUDC_CNT_OFS: rdata_d = cnt_q;
            QUDC_MAX_OFS: rdata_d = max_q;
            QUDC_MIN_OFS: rdata_d = min_q;
            QUDC_STAT_OFS: rdata_d = {27'h0, z_f, stat_q};
            QUDC_MISM_OFS: rdata_d = {16'h0000, mism_q};
            default: rdata_d = QUDC_UNMAPPED;
        endcase
    end

    // one wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read && !ack_q) begin
                avs_readdata <= rdata_d;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_q <= QUDC_CTRL_RST;
            filt_q <= QUDC_FILT_RST;
            max_q <= QUDC_MAX_RST;
            min_q <= QUDC_MIN_RST;
            mism_q <= QUDC_MISM_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= {25'h0, avs_writedata[6:0]};
            if (wr_filt) filt_q <= avs_writedata[15:0];
            if (wr_max) max_q <= avs_writedata;
            if (wr_min) min_q <= avs_writedata;
            if (wr_mism) mism_q <= avs_writedata[15:0];
        end
    end

    // count, history and status state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q <= 32'h0;
            diff_q <= 32'h0;
            stat_q <= 4'h0;
            ab_q <= 2'b00;
            z_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d; // see [RULE1]
            diff_q <= wr_cnt ? 32'h0 : diff_d;
            stat_q <= stat_d;
            ab_q <= ab_now;
            z_q <= z_f;
        end
    end

    // event strobes to the timer are registered one-cycle pulses
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count_up_evt <= 1'b0;
            count_dn_evt <= 1'b0;
            count_evt <= 1'b0;
        end else begin
            count_up_evt <= go_up; // see [RULE6]
            count_dn_evt <= go_dn; // see [RULE6]
            count_evt <= go_up | go_dn; // see [RULE6]
        end
    end

    // flags: warning to processor, mismatch to fault unit if routed there
    assign warn_irq = stat_q[QUDC_ST_MAX] | stat_q[QUDC_ST_MIN]
                    | (stat_q[QUDC_ST_MISM] & ~ctrl_q[QUDC_CTRL_FAULT]);
    assign mism_fault = stat_q[QUDC_ST_MISM]
                      & ctrl_q[QUDC_CTRL_FAULT]; // see [RULE9]
endmodule : qudc_counter

// ==== tb/qudc_checker.sv ====
/* qudc_checker: port assertions for qudc_counter.
   assumes one clock and the synchronous active-low reset. */
`timescale 1ns/100ps
module qudc_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic count_up_evt,
    input wire logic count_dn_evt,
    input wire logic count_evt,
    input wire logic warn_irq,
    input wire logic mism_fault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // any request up on the bus
    wire req = avs_read | avs_write;
    // one wait cycle per access, never more, never unasked
    wait_first_a: assert property (
        req && !$past(req) |-> avs_waitrequest) else $error("no wait cycle");
    wait_once_a: assert property (
        req && avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
    ack_once_a: assert property (
        req && !avs_waitrequest |=> !req || avs_waitrequest)
        else $error("two acks in a row");
    wait_cause_a: assert property (
        avs_waitrequest |-> req) else $error("wait without request");
    rdata_hold_a: assert property (
        !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
    // step pulses agree with each other
    evt_excl_a: assert property (
        !(count_up_evt && count_dn_evt)) else $error("up and down at once");
    evt_sum_a: assert property (
        count_evt == (count_up_evt || count_dn_evt))
        else $error("timer feed differs from steps");
    rst_quiet_a: assert property (
        $rose(reset_n) |-> !count_evt && !warn_irq && !mism_fault)
        else $error("output active out of reset");
endmodule : qudc_checker

bind qudc_counter qudc_checker chk_i (.clk_sys, .reset_n, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .count_up_evt,
    .count_dn_evt, .count_evt, .warn_irq, .mism_fault);

// ==== tb/qudc_encoder_model.sv ====
/* qudc_encoder_model: encoder and push-button far side, run by tasks.
   HOLD must exceed the filter setting or codes are lost. */
`timescale 1ns/100ps
module qudc_encoder_model #(
    parameter int HOLD = 8
) (
    input wire logic clk_sys,
    output logic enc_a,
    output logic enc_b,
    output logic enc_z
);
    initial begin
        {enc_b, enc_a, enc_z} = 3'h0;
    end
    // new {b,a} code and button level, then rest HOLD cycles
    task automatic put(input logic [1:0] ba, input logic z);
        @(posedge clk_sys);
        {enc_b, enc_a} <= ba;
        enc_z <= z;
        repeat (HOLD) @(posedge clk_sys);
    endtask : put
    // one-cycle spike on pin a, as contact bounce would give
    task automatic glitch();
        @(posedge clk_sys);
        enc_a <= ~enc_a;
        @(posedge clk_sys);
        enc_a <= ~enc_a;
        repeat (HOLD) @(posedge clk_sys);
    endtask : glitch
endmodule : qudc_encoder_model

// ==== tb/quadrature_updown_counter_test.sv ====
/* quadrature_updown_counter_test: register-level regression of qudc_counter.
   assumes the encoder model beside it and the bound checker. */
`timescale 1ns/100ps
module quadrature_updown_counter_test;
    import qudc_pkg::*;
    logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
    logic enc_a, enc_b, enc_z, count_up_evt, count_dn_evt, count_evt;
    logic warn_irq, mism_fault;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [11:0] codes = 12'h6ed;
    logic [2:0] md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    logic [31:0] cnt_x [5] = '{32'hffff_ffff, 32'h3, 32'hffff_ffff,
        32'h2, 32'h0};
    int ups [5] = '{2, 4, 1, 3, 0};
    int dns [5] = '{3, 1, 2, 1, 0};
    int err_count, samples_checked, n_up, n_dn, u0, d0;
    qudc_counter uut (.clk_sys, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .enc_a,
        .enc_b, .enc_z, .count_up_evt, .count_dn_evt, .count_evt, .warn_irq,
        .mism_fault);
    qudc_encoder_model #(.HOLD(8)) enc (.clk_sys, .enc_a, .enc_b, .enc_z);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // tally step pulses; they stand one cycle only
    always @(posedge clk_sys) begin
        n_up <= n_up + count_up_evt;
        n_dn <= n_dn + count_dn_evt;
    end
    // one access; held until waitrequest is seen low at a rising edge,
    // read data taken at that edge; only the watchdog ends a stuck wait
    task automatic bus(input logic wr, input logic [4:0] a,
            input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic chk(input string what, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rchk(input string w, input logic [4:0] a,
            input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(w, rd, e);
    endtask : rchk
    task automatic pins(input string w, input logic [31:0] e);
        @(negedge clk_sys);
        chk(w, {30'h0, warn_irq, mism_fault}, e);
    endtask : pins
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    // cut a hang short; the tests need about six hundred cycles
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {err_count, samples_checked} = '0;
        reset_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        rchk("ctrl", QUDC_CTRL_OFS, QUDC_CTRL_RST);
        rchk("filt", QUDC_FILT_OFS, {16'h0, QUDC_FILT_RST});
        rchk("max", QUDC_MAX_OFS, QUDC_MAX_RST);
        rchk("min", QUDC_MIN_OFS, QUDC_MIN_RST);
        rchk("mism", QUDC_MISM_OFS, {16'h0, QUDC_MISM_RST});
        bus(1'b1, 5'h1c, 32'hffff_ffff);
        rchk("unmapped", 5'h1c, QUDC_UNMAPPED);
        $display("reset test over");
        // same code walk in modes 0 to 3 and illegal code 5, incl. a double jump
        bus(1'b1, QUDC_FILT_OFS, 32'h2);
        for (int i = 0; i < 5; i++) begin
            enc.put(2'b00, 1'b0);
            bus(1'b1, QUDC_CTRL_OFS, {28'h0, md[i], 1'b1});
            bus(1'b1, QUDC_CNT_OFS, 32'h0);
            u0 = n_up;
            d0 = n_dn;
            for (int k = 10; k >= 0; k -= 2) enc.put(codes[k+:2], 1'b0);
            rchk("count", QUDC_CNT_OFS, cnt_x[i]);
            chk("ups", n_up - u0, ups[i]);
            chk("downs", n_dn - d0, dns[i]);
        end
        bus(1'b1, QUDC_CTRL_OFS, 32'h1);
        u0 = n_up + n_dn;
        enc.glitch();
        chk("glitch", n_up + n_dn - u0, 0);
        $display("mode test over");
        // boundary: flag first, then auto-zero
        bus(1'b1, QUDC_MAX_OFS, 32'h1);
        enc.put(2'b00, 1'b0);
        bus(1'b1, QUDC_CNT_OFS, 32'h0);
        enc.put(2'b01, 1'b0);
        enc.put(2'b11, 1'b0);
        rchk("over max", QUDC_STAT_OFS, 32'h1);
        pins("warn", 32'h2);
        bus(1'b1, QUDC_STAT_OFS, 32'h1f);
        pins("warn cleared", 32'h0);
        bus(1'b1, QUDC_CTRL_OFS, 32'h21);
        enc.put(2'b10, 1'b0);
        rchk("auto zero", QUDC_CNT_OFS, 32'h0);
        $display("boundary test over");
        // marker clears the count; button level shows live
        bus(1'b1, QUDC_CTRL_OFS, 32'h11);
        bus(1'b1, QUDC_STAT_OFS, 32'h1f);
        enc.put(2'b11, 1'b0);
        enc.put(2'b11, 1'b1);
        rchk("marker", QUDC_STAT_OFS, 32'h18);
        rchk("zeroed", QUDC_CNT_OFS, 32'h0);
        enc.put(2'b11, 1'b0);
        $display("marker test over");
        // three a rises against none on b, limit two
        bus(1'b1, QUDC_CTRL_OFS, 32'h9);
        bus(1'b1, QUDC_MISM_OFS, 32'h2);
        bus(1'b1, QUDC_CNT_OFS, 32'h0);
        bus(1'b1, QUDC_STAT_OFS, 32'h1f);
        for (int k = 0; k < 3; k++) begin
            enc.put(2'b10, 1'b0);
            enc.put(2'b11, 1'b0);
            if (k == 1) rchk("in range", QUDC_STAT_OFS, 32'h0);
        end
        rchk("mismatch", QUDC_STAT_OFS, 32'h4);
        pins("to cpu", 32'h2);
        bus(1'b1, QUDC_CTRL_OFS, 32'h49);
        pins("to fault", 32'h1);
        $display("mismatch test over");
        end_of_test();
    end
endmodule : quadrature_updown_counter_test
